/* include/scp_defs.svh */
// Constants for the serial control port front end.
// Assumes a 40 MHz core clock and a host-driven serial clock.
// Contract
// - Mode pin low plus enable high selects two-wire
// - Both mode and enable low resets device
// - SPI transfers are whole 8-bit bytes
// - SPI: clock in, data in, separate out
// - SPI traffic only with enable high; else Hi-Z
// - Enable rise resets framing, awaits command
// - Sync string regains alignment with enable high
// - Two-wire mode keeps SPI output Hi-Z
// - Slave only, never drives serial clock
// - Carries config, returns data, accepts characters
// - Shared pin: sync input or interrupt output
// - Video vertical lock makes pin interrupt output
// - Interrupt only on selected packet type
// - Interrupt pending until host clears it
// - Documented reset defaults on reset
// - Host selects locks, standard, raw/filtered
// - Two-wire slave address 28h write, 29h read
`ifndef SCP_DEFS_SVH
`define SCP_DEFS_SVH
`define SCP_I2C_ADDR   7'h14
`define SCP_BYTE_LAST  3'h7
`define SCP_SYNC_ONES  5'h10
`define SCP_CMD_CFG    8'h01
`define SCP_CMD_DISP   8'h02
`define SCP_CMD_IRQSEL 8'h03
`define SCP_CMD_IRQCLR 8'h04
`define SCP_CMD_OSD    8'h05
`define SCP_CMD_ROWS   8'h06
`define SCP_CMD_BOX    8'h07
`define SCP_RST_CFG    8'h00
`define SCP_RST_DISP   8'h40
`define SCP_RST_ROWS   4'hf
`define SCP_RST_SEL    4'h0
`define SCP_CFG_VEXT   0
`define SCP_CFG_HEXT   1
`define SCP_CFG_PAL    2
`define SCP_CFG_RAW    3
`define SCP_CFG_IRQEN  4
`define SCP_CFG_DOUT   5
`define SCP_CLK_NS     25
`define SCP_BOX_NS     13500
`define SCP_BOX_CYC    (`SCP_BOX_NS / `SCP_CLK_NS)
`endif

/* include/scp_pkg.sv */
// Types for the serial control port front end.
// Assumes scp_defs.svh supplies the numeric constants.
package scp_pkg;
  typedef enum logic [2:0] {
    I2C_IDLE = 3'b000,
    I2C_ADDR = 3'b001,
    I2C_AACK = 3'b010,
    I2C_WR   = 3'b011,
    I2C_WACK = 3'b100,
    I2C_RD   = 3'b101,
    I2C_RACK = 3'b110
  } scp_i2c_e;
  typedef logic [7:0] scp_byte_t;
endpackage : scp_pkg

/* rtl/scp_serial_port.sv */
// Serial control port front end: mode select, two-wire and SPI slaves,
// command decoder, configuration and the shared sync/interrupt pin.
// Assumes a decoder core feeding packet and data strobes on clk.
`timescale 1ns/100ps
`include "scp_defs.svh"
module scp_serial_port #(
  parameter int BOX_W = 10
) (
  input  wire logic               clk,
  input  wire logic               arst_n,
  input  wire logic               serial_clk,
  input  wire logic               serial_mode_select_pin,
  input  wire logic               port_enable_pin,
  input  wire logic               sda_i,
  output logic                    sda_o,
  output logic                    sda_oe,
  output logic                    spi_output_pin,
  output logic                    spi_output_oe,
  input  wire logic               sync_in_or_irq_i,
  output logic                    sync_in_or_irq_o,
  output logic                    sync_in_or_irq_oe,
  input  wire logic               pkt_valid,
  input  wire logic [3:0]         pkt_type,
  input  wire logic               xds_valid,
  input  wire scp_pkg::scp_byte_t xds_byte,
  output logic                    device_reset,
  output logic                    irq_request_out,
  output logic                    ext_vsync,
  output logic                    osd_char_valid,
  output scp_pkg::scp_byte_t      osd_char,
  output logic [2:0]              display_channel,
  output logic                    decoder_on,
  output logic                    lines15,
  output logic                    shadow_bg,
  output logic                    ext_attr,
  output logic [3:0]              text_rows,
  output logic [BOX_W-1:0]        box_cycles,
  output logic                    data_out_on,
  output logic                    pal_mode,
  output logic                    vlock_ext,
  output logic                    hlock_ext,
  output logic                    raw_out,
  output logic                    irq_enable
);
  import scp_pkg::*;

  // ****************************************************************
  // Parameter check
  // ****************************************************************
  if (BOX_W < 10) begin : g_chk
    $error("BOX_W too narrow for box timing count");
  end

  // ****************************************************************
  // Pin synchronisers into clk
  // ****************************************************************
  logic [3:0] pin_s1_reg, pin_s2_reg;
  logic       scl_d_reg, sda_d_reg, vs_reg, sda_s1_reg, sda_s2_reg;
  logic [7:0] out_byte_reg;
  logic       dav_reg, tx_tgl_reg, irq_pend_reg;
  // Mode, enable, clock, data: two flops before use; sync in: three
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pin_s1_reg <= 4'h1;                                    // Clock idles high
      pin_s2_reg <= 4'h1;
      scl_d_reg  <= 1'b1;
      sda_d_reg  <= 1'b1;
      vs_reg     <= 1'b0;
    end else begin
      pin_s1_reg <= {sync_in_or_irq_i, serial_mode_select_pin,
                     port_enable_pin, serial_clk};
      pin_s2_reg <= pin_s1_reg;
      scl_d_reg  <= pin_s2_reg[0];
      sda_d_reg  <= sda_s2_reg;
      vs_reg     <= pin_s2_reg[3];
    end
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sda_s1_reg <= 1'b1;
      sda_s2_reg <= 1'b1;
    end else begin
      sda_s1_reg <= sda_i;
      sda_s2_reg <= sda_s1_reg;
    end
  end

  // Decoded pin levels and edges
  wire sda_s    = sda_s2_reg;
  wire scl_s    = pin_s2_reg[0];
  wire en_s     = pin_s2_reg[1];
  wire spi_mode = pin_s2_reg[2];
  wire core_rst = !spi_mode && !en_s;
  wire i2c_on   = !spi_mode && en_s;
  wire scl_rise = scl_s && !scl_d_reg;
  wire scl_fall = !scl_s && scl_d_reg;
  wire i2c_strt = scl_s && scl_d_reg && sda_d_reg && !sda_s;
  wire i2c_stop = scl_s && scl_d_reg && !sda_d_reg && sda_s;

  // ****************************************************************
  // SPI link domain (serial_clk)
  // ****************************************************************
  wire spi_rst_n = arst_n && port_enable_pin && serial_mode_select_pin;
  logic [2:0] sbit_reg;
  logic [7:0] sin_reg;
  logic [8:0] shold_reg;
  logic       stgl_reg, sfirst_reg, tx_s1_reg, tx_s2_reg, tx_seen_reg;
  logic       ack_tgl_reg;
  logic [4:0] ones_reg;
  // Sync takes effect on the last one, so the next bit opens a command
  wire        sync_hit = sda_i && (ones_reg == `SCP_SYNC_ONES - 5'h01);
  // Whole bytes only; framing restarts when enable rises
  always_ff @(posedge serial_clk or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      sbit_reg   <= 3'h0;
      sin_reg    <= 8'h00;
      shold_reg  <= 9'h000;
      stgl_reg   <= 1'b0;
      sfirst_reg <= 1'b1;
      ones_reg   <= 5'h00;
    end else if (sync_hit) begin
      sbit_reg   <= 3'h0;
      sfirst_reg <= 1'b1;
      ones_reg   <= 5'h00;
    end else begin
      sin_reg  <= {sin_reg[6:0], sda_i};
      sbit_reg <= sbit_reg + 3'h1;
      ones_reg <= sda_i ? ones_reg + 5'h01 : 5'h00;
      if (sbit_reg == `SCP_BYTE_LAST) begin
        shold_reg  <= {sfirst_reg, sin_reg[6:0], sda_i};
        stgl_reg   <= !stgl_reg;
        sfirst_reg <= 1'b0;
      end
    end
  end
  // Outgoing data handshake, seen at byte boundaries
  always_ff @(posedge serial_clk or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      tx_s1_reg <= 1'b0;
      tx_s2_reg <= 1'b0;
    end else begin
      tx_s1_reg <= tx_tgl_reg;
      tx_s2_reg <= tx_s1_reg;
    end
  end
  logic [7:0] sout_reg;
  // Shift out on falling edge, MSB first, load at byte start
  always_ff @(negedge serial_clk or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      sout_reg    <= 8'h00;
      tx_seen_reg <= 1'b0;
      ack_tgl_reg <= 1'b0;
    end else if (sbit_reg == 3'h0) begin
      sout_reg    <= (tx_s2_reg != tx_seen_reg) ? out_byte_reg : 8'h00;
      tx_seen_reg <= tx_s2_reg;
      ack_tgl_reg <= ack_tgl_reg ^ (tx_s2_reg != tx_seen_reg);
    end else begin
      sout_reg <= {sout_reg[6:0], 1'b0};
    end
  end
  assign spi_output_pin = sout_reg[7];
  assign spi_output_oe  = spi_mode && en_s;

  // ****************************************************************
  // Crossing of SPI bytes and acks into clk
  // ****************************************************************
  logic [2:0] rx_sy_reg, ak_sy_reg;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rx_sy_reg <= 3'h0;
      ak_sy_reg <= 3'h0;
    end else begin
      rx_sy_reg <= {rx_sy_reg[1:0], stgl_reg};
      ak_sy_reg <= {ak_sy_reg[1:0], ack_tgl_reg};
    end
  end
  wire spi_byte = spi_mode && (rx_sy_reg[2] != rx_sy_reg[1]);
  wire spi_ack  = ak_sy_reg[2] != ak_sy_reg[1];

  // ****************************************************************
  // Two-wire slave in clk
  // ****************************************************************
  scp_i2c_e   ist_reg, ist_next;
  logic [3:0] ibit_reg;
  logic [7:0] ish_reg, itx_reg;
  logic       irw_reg, inack_reg, ifirst_reg, irdat_reg;
  wire        i8     = (ibit_reg == 4'h8);
  wire        amatch = (ish_reg[7:1] == `SCP_I2C_ADDR);
  wire        i2c_wbyte = i2c_on && scl_fall && i8 && (ist_reg == I2C_WR);
  wire        i2c_rdone = scl_fall && i8 && (ist_reg == I2C_RD) && irdat_reg;
  wire [7:0]  status = {1'b1, dav_reg, irq_pend_reg, spi_mode, 4'h0};
  // State sequencing on clock falls, start and stop
  always_comb begin
    ist_next = ist_reg;
    unique case (ist_reg)
      I2C_IDLE: ist_next = I2C_IDLE;
      I2C_ADDR: if (scl_fall && i8) ist_next = amatch ? I2C_AACK : I2C_IDLE;
      I2C_AACK: if (scl_fall) ist_next = irw_reg ? I2C_RD : I2C_WR;
      I2C_WR:   if (scl_fall && i8) ist_next = I2C_WACK;
      I2C_WACK: if (scl_fall) ist_next = I2C_WR;
      I2C_RD:   if (scl_fall && i8) ist_next = I2C_RACK;
      I2C_RACK: if (scl_fall) ist_next = inack_reg ? I2C_IDLE : I2C_RD;
      default:  ist_next = I2C_IDLE;
    endcase
    if (i2c_strt) ist_next = I2C_ADDR;
    if (i2c_stop || !i2c_on) ist_next = I2C_IDLE;
  end
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) ist_reg <= I2C_IDLE;
    else ist_reg <= ist_next;
  end
  // Bit count, shift in on rise, shift out on fall
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      ibit_reg <= 4'h0; ish_reg <= 8'h00; itx_reg <= 8'hff;
      irw_reg <= 1'b0; inack_reg <= 1'b1; ifirst_reg <= 1'b0;
      irdat_reg <= 1'b0;
    end else if (ist_next != ist_reg) begin
      ibit_reg <= 4'h0;
      if (ist_reg == I2C_ADDR) irw_reg <= ish_reg[0];
      if (ist_next == I2C_WR && ist_reg == I2C_AACK) ifirst_reg <= 1'b1;
      if (ist_reg == I2C_WR) ifirst_reg <= 1'b0;
      if (ist_next == I2C_RD) begin
        itx_reg   <= (ist_reg == I2C_AACK) ? status : out_byte_reg;
        irdat_reg <= (ist_reg == I2C_RACK);
      end
    end else begin
      if (scl_rise) begin
        ish_reg  <= {ish_reg[6:0], sda_s};
        ibit_reg <= ibit_reg + 4'h1;
        if (ist_reg == I2C_RACK) inack_reg <= sda_s;
      end
      if (scl_fall && ist_reg == I2C_RD) itx_reg <= {itx_reg[6:0], 1'b1};
    end
  end
  // Open drain: pull low for acks and zero data bits only
  assign sda_o  = 1'b0;
  assign sda_oe = i2c_on && ((ist_reg == I2C_AACK) ||
                  (ist_reg == I2C_WACK) ||
                  (ist_reg == I2C_RD && !itx_reg[7]));

  // ****************************************************************
  // Command decoder and configuration
  // ****************************************************************
  wire       byte_vld   = spi_byte || i2c_wbyte;
  wire [7:0] byte_dat   = spi_byte ? shold_reg[7:0] : ish_reg;
  wire       byte_first = spi_byte ? shold_reg[8] : ifirst_reg;
  logic [7:0] cmd_reg, cfg_reg, disp_reg;
  logic [3:0] rows_reg, sel_reg;
  logic [BOX_W-1:0] box_reg;
  logic       need_reg, osd_v_reg;
  logic [7:0] osd_reg;
  wire        is_cmd = byte_vld && (byte_first || !need_reg);
  wire        is_dat = byte_vld && !is_cmd;
  wire        irq_clr = is_cmd && (byte_dat == `SCP_CMD_IRQCLR);
  // Command byte, then its data byte; the interrupt clear command has none
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cmd_reg <= 8'h00; need_reg <= 1'b0;
      cfg_reg <= `SCP_RST_CFG; disp_reg <= `SCP_RST_DISP;
      rows_reg <= `SCP_RST_ROWS; sel_reg <= `SCP_RST_SEL;
      box_reg <= BOX_W'(`SCP_BOX_CYC);
      osd_v_reg <= 1'b0; osd_reg <= 8'h00;
    end else if (core_rst) begin
      cmd_reg <= 8'h00; need_reg <= 1'b0;
      cfg_reg <= `SCP_RST_CFG; disp_reg <= `SCP_RST_DISP;
      rows_reg <= `SCP_RST_ROWS; sel_reg <= `SCP_RST_SEL;
      box_reg <= BOX_W'(`SCP_BOX_CYC);
      osd_v_reg <= 1'b0;
    end else begin
      osd_v_reg <= 1'b0;
      if (is_cmd) begin
        cmd_reg  <= byte_dat;
        need_reg <= (byte_dat != `SCP_CMD_IRQCLR);
      end
      if (is_dat) begin
        need_reg <= 1'b0;
        if (cmd_reg == `SCP_CMD_CFG) cfg_reg <= byte_dat;
        if (cmd_reg == `SCP_CMD_DISP) disp_reg <= byte_dat;
        if (cmd_reg == `SCP_CMD_ROWS) rows_reg <= byte_dat[3:0];
        if (cmd_reg == `SCP_CMD_IRQSEL) sel_reg <= byte_dat[3:0];
        if (cmd_reg == `SCP_CMD_BOX) box_reg <= BOX_W'({byte_dat, 2'b00});
        if (cmd_reg == `SCP_CMD_OSD) begin
          osd_v_reg <= 1'b1;
          osd_reg   <= byte_dat;
        end
      end
    end
  end

  // ****************************************************************
  // Returned data and interrupt state
  // ****************************************************************
  wire        dav_set = xds_valid && !dav_reg;
  wire        irq_hit = pkt_valid && (pkt_type == sel_reg) &&
                        cfg_reg[`SCP_CFG_IRQEN];
  // Data held stable until read out; new data only when empty
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      out_byte_reg <= 8'h00; dav_reg <= 1'b0;
      tx_tgl_reg <= 1'b0; irq_pend_reg <= 1'b0;
    end else if (core_rst) begin
      dav_reg <= 1'b0; irq_pend_reg <= 1'b0;
    end else begin
      if (dav_set) begin
        out_byte_reg <= xds_byte;
        tx_tgl_reg   <= !tx_tgl_reg;
      end
      dav_reg <= dav_set || (dav_reg && !(i2c_rdone || spi_ack));
      irq_pend_reg <= irq_hit || (irq_pend_reg && !irq_clr);
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign device_reset      = core_rst;
  assign irq_request_out   = irq_pend_reg;
  assign sync_in_or_irq_oe = !cfg_reg[`SCP_CFG_VEXT];
  assign sync_in_or_irq_o  = irq_pend_reg;
  assign ext_vsync         = cfg_reg[`SCP_CFG_VEXT] && vs_reg;
  assign osd_char_valid    = osd_v_reg;
  assign osd_char          = osd_reg;
  assign display_channel   = disp_reg[2:0];
  assign decoder_on        = disp_reg[3];
  assign lines15           = disp_reg[4];
  assign shadow_bg         = disp_reg[5];
  assign ext_attr          = disp_reg[6];
  assign text_rows         = rows_reg;
  assign box_cycles        = box_reg;
  assign data_out_on       = cfg_reg[`SCP_CFG_DOUT];
  assign pal_mode          = cfg_reg[`SCP_CFG_PAL];
  assign vlock_ext         = cfg_reg[`SCP_CFG_VEXT];
  assign hlock_ext         = cfg_reg[`SCP_CFG_HEXT];
  assign raw_out           = cfg_reg[`SCP_CFG_RAW];
  assign irq_enable        = cfg_reg[`SCP_CFG_IRQEN];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  reset_defaults_a: assert property (@(posedge clk) disable iff (!arst_n)
    core_rst |=> !decoder_on && display_channel == 3'h0 && !irq_enable
      && text_rows == `SCP_RST_ROWS && ext_attr && !pal_mode)
    else $error("reset defaults wrong");
  reset_entry_a: assert property (@(posedge clk) disable iff (!arst_n)
    (!spi_mode && !en_s) |-> device_reset)
    else $error("device not held in reset");
  spi_hiz_a: assert property (@(posedge clk) disable iff (!arst_n)
    (!en_s || !spi_mode) |-> !spi_output_oe)
    else $error("spi output driven while disabled");
  i2c_quiet_a: assert property (@(posedge clk) disable iff (!arst_n)
    spi_mode |-> !sda_oe)
    else $error("two-wire data driven in spi mode");
  irq_pin_dir_a: assert property (@(posedge clk) disable iff (!arst_n)
    !vlock_ext |-> sync_in_or_irq_oe && (sync_in_or_irq_o == irq_pend_reg))
    else $error("shared pin not interrupt output");
  irq_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
    irq_pend_reg && !irq_clr && !core_rst |=> irq_pend_reg)
    else $error("interrupt dropped without clear");
  irq_filter_a: assert property (@(posedge clk) disable iff (!arst_n)
    !irq_pend_reg && !core_rst ##1 irq_pend_reg
      |-> $past(pkt_valid) && $past(pkt_type) == $past(sel_reg))
    else $error("interrupt raised on wrong packet");
  addr_ack_a: assert property (@(posedge clk) disable iff (!arst_n)
    (ist_reg == I2C_AACK) && $changed(ist_reg)
      |-> $past(ish_reg[7:1]) == `SCP_I2C_ADDR)
    else $error("acked wrong slave address");
  osd_path_a: assert property (@(posedge clk) disable iff (!arst_n)
    is_dat && cmd_reg == `SCP_CMD_OSD && !core_rst
      |=> osd_char_valid && osd_char == $past(byte_dat))
    else $error("character not passed on");
  cfg_write_c: cover property (@(posedge clk) disable iff (!arst_n)
    is_dat && cmd_reg == `SCP_CMD_CFG);
  irq_cycle_c: cover property (@(posedge clk) disable iff (!arst_n)
    irq_pend_reg ##[1:200] irq_clr);
  i2c_read_c: cover property (@(posedge clk) disable iff (!arst_n)
    i2c_rdone);
endmodule : scp_serial_port

/* dv/scp_host_model.sv */
// Host model: serial bus master for both link modes of the control port.
// Assumes the device splits its data pin into sda_o/sda_oe, line pulled up.
`timescale 1ns/100ps
module scp_host_model (
  output logic      serial_clk,
  output logic      serial_mode_select_pin,
  output logic      port_enable_pin,
  output logic      sda_i,
  input  wire logic sda_o,
  input  wire logic sda_oe,
  input  wire logic spi_output_pin,
  input  wire logic spi_output_oe
);
  // ****************
  // Line and pins
  // ****************
  logic host_sda;
  // Pulled-up open-drain line; the device only ever pulls it low
  assign sda_i = host_sda & ~(sda_oe & ~sda_o);

  initial begin
    serial_mode_select_pin = 1'b0;
    port_enable_pin        = 1'b1;
    serial_clk             = 1'b1;
    host_sda               = 1'b1;
  end

  // Mode and enable change; clock idles high in two-wire, low in SPI
  task automatic pins(input logic mode, input logic en);
    serial_mode_select_pin = mode;
    port_enable_pin        = en;
    serial_clk             = ~mode;
    #300;
  endtask : pins

  // ****************
  // Two-wire cycles
  // ****************
  // Data moves only while the clock is low; sampled mid-high
  task automatic i2c_bit(input logic tx, output logic rx);
    #100 host_sda = tx;
    #100 serial_clk = 1'b1;
    #100 rx = sda_i;
    #100 serial_clk = 1'b0;
  endtask : i2c_bit

  task automatic i2c_start();
    host_sda = 1'b1;
    #100 serial_clk = 1'b1;
    #200 host_sda = 1'b0;
    #200 serial_clk = 1'b0;
  endtask : i2c_start

  task automatic i2c_stop();
    #100 host_sda = 1'b0;
    #100 serial_clk = 1'b1;
    #200 host_sda = 1'b1;
    #200;
  endtask : i2c_stop

  // One byte MSB first, then the ninth bit
  task automatic i2c_byte(input logic [7:0] tx, input logic ai,
                          output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) i2c_bit(tx[i], rx[i]);
    i2c_bit(ai, ack);
  endtask : i2c_byte

  // ****************
  // SPI cycles
  // ****************
  // First n bits of a byte, MSB first; clock stands low outside the byte
  task automatic spi_bits(input logic [7:0] tx, input int n,
                          output logic [7:0] rx);
    for (int i = 7; i > 7 - n; i--) begin
      host_sda = tx[i];
      #40 serial_clk = 1'b1;
      rx[i] = spi_output_pin;
      #40 serial_clk = 1'b0;
    end
    host_sda = ~host_sda;
  endtask : spi_bits
endmodule : scp_host_model

/* dv/scp_serial_port_tb.sv */
// Testbench for the serial control port: two-wire traffic and read-back,
// then reset, table of SPI writes, interrupt, framing and sync cases.
// Assumes scp_host_model drives the link pins as the host.
`timescale 1ns/100ps
module scp_serial_port_tb;
  import scp_pkg::*;
  // ****************
  // Signals
  // ****************
  logic clk, arst_n, sclk, mode, en, sda_i, sda_o, sda_oe, spo, spo_oe;
  logic sync_i, sync_o, sync_oe, pkt_valid, xds_valid, device_reset, irq;
  logic ext_vsync, osd_v, decoder_on, lines15, shadow_bg, ext_attr;
  logic data_out_on, pal_mode, vlock_ext, hlock_ext, raw_out, irq_enable;
  logic ack;
  logic [3:0] pkt_type, text_rows;
  logic [2:0] display_channel;
  logic [9:0] box_cycles;
  scp_byte_t  xds_byte, osd_c, osd_seen, rx;
  int         error_cnt = 0;
  int         n_compared = 0;
  typedef struct packed {
    logic [7:0] cmd; logic [7:0] dat; logic [1:0] sel; logic [9:0] exp;
  } scp_row_s;
  scp_row_s rows [6] = '{'{8'h01, 8'h2e, 2'h0, 10'h02e},
    '{8'h02, 8'h1d, 2'h1, 10'h01d}, '{8'h02, 8'h67, 2'h1, 10'h067},
    '{8'h06, 8'h0a, 2'h2, 10'h00a}, '{8'h07, 8'h21, 2'h3, 10'h084},
    '{8'h07, 8'hff, 2'h3, 10'h3fc}};

  scp_serial_port scp_serial_port_inst (.clk(clk), .arst_n(arst_n),
    .serial_clk(sclk), .serial_mode_select_pin(mode),
    .port_enable_pin(en), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe),
    .spi_output_pin(spo), .spi_output_oe(spo_oe),
    .sync_in_or_irq_i(sync_i), .sync_in_or_irq_o(sync_o),
    .sync_in_or_irq_oe(sync_oe), .pkt_valid(pkt_valid),
    .pkt_type(pkt_type), .xds_valid(xds_valid), .xds_byte(xds_byte),
    .device_reset(device_reset), .irq_request_out(irq),
    .ext_vsync(ext_vsync), .osd_char_valid(osd_v), .osd_char(osd_c),
    .display_channel(display_channel), .decoder_on(decoder_on),
    .lines15(lines15), .shadow_bg(shadow_bg), .ext_attr(ext_attr),
    .text_rows(text_rows), .box_cycles(box_cycles),
    .data_out_on(data_out_on), .pal_mode(pal_mode), .vlock_ext(vlock_ext),
    .hlock_ext(hlock_ext), .raw_out(raw_out), .irq_enable(irq_enable));
  scp_host_model scp_host_model_inst (.serial_clk(sclk),
    .serial_mode_select_pin(mode), .port_enable_pin(en), .sda_i(sda_i),
    .sda_o(sda_o), .sda_oe(sda_oe), .spi_output_pin(spo),
    .spi_output_oe(spo_oe));

  // Core clock and capture of the one-cycle character strobe
  initial clk = 1'b0;
  always #12.5 clk = ~clk;
  always @(posedge clk) if (osd_v) osd_seen <= osd_c;

  // ****************
  // Tasks
  // ****************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("compared=%0d errors=%0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run

  // Config fields gathered in command-data bit order
  function automatic logic [15:0] view(input logic [1:0] sel);
    case (sel)
      2'h0: view = {10'h000, data_out_on, irq_enable, raw_out, pal_mode,
                    hlock_ext, vlock_ext};
      2'h1: view = {9'h000, ext_attr, shadow_bg, lines15, decoder_on,
                    display_channel};
      2'h2: view = {12'h000, text_rows};
      default: view = {6'h00, box_cycles};
    endcase
  endfunction : view

  task automatic check_defaults();
    check(view(2'h0), 16'h0000);
    check(view(2'h1), 16'h0040);
    check(view(2'h2), 16'h000f);
    check(view(2'h3), 16'h021c);
    check({irq, sync_oe, spo_oe}, 16'h0002);
  endtask : check_defaults

  task automatic ib(input logic [7:0] tx, input logic ai,
                    input logic [7:0] exp, input logic ea);
    scp_host_model_inst.i2c_byte(tx, ai, rx, ack);
    check(ack, ea);
    if (tx == 8'hff) check(rx, exp);
  endtask : ib

  task automatic spi_write(input logic [7:0] c, input logic [7:0] d);
    scp_host_model_inst.spi_bits(c, 8, rx);
    scp_host_model_inst.spi_bits(d, 8, rx);
    repeat (8) @(posedge clk);
  endtask : spi_write

  task automatic strobe(input logic is_pkt, input logic [7:0] v);
    @(posedge clk);
    if (is_pkt) begin
      pkt_type  <= v[3:0];
      pkt_valid <= 1'b1;
    end else begin
      xds_byte  <= v;
      xds_valid <= 1'b1;
    end
    @(posedge clk);
    pkt_valid <= 1'b0;
    xds_valid <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : strobe

  task automatic wait_irq(input logic lvl);
    int k;
    for (k = 0; k < 20 && irq !== lvl; k++) @(posedge clk);
    check(irq, lvl);
    if (k == 20) complete_run();
  endtask : wait_irq

  // ****************
  // Main sequence
  // ****************
  initial begin
    {arst_n, pkt_valid, pkt_type, xds_valid, xds_byte, sync_i} = '0;
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (8) @(posedge clk);
    check_defaults();
    // Two-wire write, foreign address, status and data read-back
    scp_host_model_inst.i2c_start();
    ib(8'h28, 1'b1, 8'h00, 1'b0);
    ib(8'h06, 1'b1, 8'h00, 1'b0);
    ib(8'h07, 1'b1, 8'h00, 1'b0);
    scp_host_model_inst.i2c_stop();
    check(text_rows, 16'h0007);
    scp_host_model_inst.i2c_start();
    ib(8'h30, 1'b1, 8'h00, 1'b1);
    scp_host_model_inst.i2c_stop();
    strobe(1'b0, 8'ha5);
    scp_host_model_inst.i2c_start();
    ib(8'h29, 1'b1, 8'h00, 1'b0);
    ib(8'hff, 1'b0, 8'hc0, 1'b0);
    ib(8'hff, 1'b1, 8'ha5, 1'b1);
    scp_host_model_inst.i2c_stop();
    scp_host_model_inst.i2c_start();
    ib(8'h29, 1'b1, 8'h00, 1'b0);
    ib(8'hff, 1'b1, 8'h80, 1'b1);
    scp_host_model_inst.i2c_stop();
    // Reset through mode and enable pins
    scp_host_model_inst.pins(1'b0, 1'b0);
    check(device_reset, 16'h0001);
    check_defaults();
    // SPI table of command and data pairs
    scp_host_model_inst.pins(1'b1, 1'b1);
    check({device_reset, spo_oe}, 16'h0001);
    foreach (rows[i]) begin
      spi_write(rows[i].cmd, rows[i].dat);
      check(view(rows[i].sel), rows[i].exp);
    end
    strobe(1'b0, 8'h3c);
    spi_write(8'h06, 8'h09);
    check({rx, text_rows}, 16'h03c9);
    spi_write(8'h05, 8'h41);
    check(osd_seen, 16'h0041);
    // Interrupt: filtered packet, held until cleared, then external sync
    spi_write(8'h01, 8'h10);
    spi_write(8'h03, 8'h05);
    strobe(1'b1, 8'h04);
    check(irq, 16'h0000);
    strobe(1'b1, 8'h05);
    wait_irq(1'b1);
    repeat (30) @(posedge clk);
    check({irq, sync_o, sync_oe}, 16'h0007);
    scp_host_model_inst.spi_bits(8'h04, 8, rx);
    wait_irq(1'b0);
    spi_write(8'h01, 8'h11);
    sync_i <= 1'b1;
    repeat (6) @(posedge clk);
    check({sync_oe, ext_vsync}, 16'h0001);
    // Broken byte then enable drop, then broken byte then sync string
    scp_host_model_inst.spi_bits(8'h00, 3, rx);
    scp_host_model_inst.pins(1'b1, 1'b0);
    check(spo_oe, 16'h0000);
    scp_host_model_inst.pins(1'b1, 1'b1);
    spi_write(8'h06, 8'h05);
    check(text_rows, 16'h0005);
    scp_host_model_inst.spi_bits(8'h00, 3, rx);
    spi_write(8'hff, 8'hff);
    spi_write(8'h06, 8'h03);
    check(text_rows, 16'h0003);
    complete_run();
  end
endmodule : scp_serial_port_tb
